// ---- verilog/pcg_regs.vh ----
`ifndef PCG_REGS_VH
`define PCG_REGS_VH

// register byte offsets from the system control base
`define PCG_RUN_GATE_OFS 12'h104
`define PCG_SLEEP_GATE_OFS 12'h114
`define PCG_DEEP_GATE_OFS 12'h124
`define PCG_RUN_CFG_OFS 12'h060
`define PCG_IRQ_STAT_OFS 12'h200
`define PCG_IRQ_MASK_OFS 12'h204
`define PCG_EFF_GATE_OFS 12'h208

// gating bit positions, same in all three gating registers
`define PCG_POS_ASYNC0 5'd0
`define PCG_POS_ASYNC1 5'd1
`define PCG_POS_ASYNC2 5'd2
`define PCG_POS_SYNC0 5'd4
`define PCG_POS_TWO_WIRE0 5'd12
`define PCG_POS_TWO_WIRE1 5'd14
`define PCG_POS_COUNTER0 5'd16
`define PCG_POS_COUNTER1 5'd17
`define PCG_POS_COUNTER2 5'd18
`define PCG_POS_COUNTER3 5'd19

// writable bits of a gating register; the rest read as zero
`define PCG_GATE_MASK 32'h000f5017
`define PCG_GATE_RESET 32'h00000000

// auto clock gating select field of the run configuration register
`define PCG_ACG_BIT 0
`define PCG_RUN_CFG_RESET 32'h00000000

`define PCG_IRQ_RESET 32'h00000000

// axi response codes
`define PCG_RESP_OKAY 2'b00
`define PCG_RESP_SLVERR 2'b10

`endif

// ---- verilog/pcg_clk_gate.v ----
`timescale 1ns/10ps
module pcg_clk_gate (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire enable_i,
   output wire unit_clk_o,
   output wire unit_en_o
);

   reg en_low_reg;

   // enable changes only while the clock is low, so no runt pulses
   always @(negedge core_clk_i) begin
      if (!rst_n_i) begin
         en_low_reg <= 1'b0;
      end else begin
         en_low_reg <= enable_i;
      end
   end

   assign unit_clk_o = core_clk_i & en_low_reg;
   assign unit_en_o = en_low_reg;

endmodule // pcg_clk_gate

// ---- verilog/pcg_fault_chk.v ----
`timescale 1ns/10ps
module pcg_fault_chk #(
   parameter N_UNITS = 10
) (
   input wire access_valid_i,
   input wire [N_UNITS-1:0] access_sel_i,
   input wire [N_UNITS-1:0] unit_en_i,
   output wire access_err_o,
   output wire [N_UNITS-1:0] fault_units_o
);

   // a select on a stopped unit is refused with an error
   assign fault_units_o = {N_UNITS{access_valid_i}} & access_sel_i &
                          ~unit_en_i;
   assign access_err_o = |fault_units_o;

endmodule // pcg_fault_chk

// ---- verilog/pcg_top.v ----
// Behaviour
// - gate bit one delivers the unit clock
// - gate bit zero stops clock, unit disabled
// - access to stopped unit ends in fault
// - all gate bits reset to zero
// - run, sleep, deep-sleep registers per state
// - sleep values apply only with auto gating
// - bits 14 and 12 gate two-wire ports
// - bit 4 gates synchronous serial port
// - bits 2..0 gate async serial ports
// - reserved bits read-only, read zero
// - sleep register at 0x114, resets zero
// - bits 19..16 gate counters 3..0
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pcg_regs.vh"
module pcg_top #(
   parameter N_UNITS = 10,
   parameter ADDR_W = 12
) (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output wire [1:0] s_axi_bresp_o,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire sleep_i,
   input wire deep_sleep_i,
   input wire periph_valid_i,
   input wire [N_UNITS-1:0] periph_sel_i,
   output wire periph_err_o,
   output wire [N_UNITS-1:0] unit_clk_o,
   output wire [N_UNITS-1:0] unit_en_o,
   output wire irq_o
);

   // unit index k sits at gate bit UNIT_POS[5k+4:5k]
   // bit map
   localparam [49:0] UNIT_POS = {
      `PCG_POS_COUNTER3, `PCG_POS_COUNTER2,
      `PCG_POS_COUNTER1, `PCG_POS_COUNTER0,
      `PCG_POS_TWO_WIRE1, `PCG_POS_TWO_WIRE0,
      `PCG_POS_SYNC0, `PCG_POS_ASYNC2,
      `PCG_POS_ASYNC1, `PCG_POS_ASYNC0};

   // register file
   reg [31:0] run_clock_gate_1_reg;
   reg [31:0] sleep_clock_gate_1_reg;
   reg [31:0] deep_sleep_clock_gate_1_reg;
   reg auto_clock_gating_select_reg;
   reg [31:0] irq_stat_reg;
   reg [31:0] irq_mask_reg;
   reg irq_reg;

   // write channel state
   reg aw_full_reg;
   reg [ADDR_W-1:0] awaddr_reg;
   reg w_full_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;

   // read channel state
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;

   // combinational helpers
   reg [31:0] eff_layout;
   reg [31:0] fault_layout;
   reg [31:0] en_layout;
   reg [31:0] rd_val;
   reg rd_hit;
   reg wr_hit;
   reg [31:0] irq_stat_next;
   integer i;

   wire [N_UNITS-1:0] eff_units;
   wire [N_UNITS-1:0] unit_en;
   wire [N_UNITS-1:0] fault_units;
   wire [31:0] wmask;
   wire wr_fire;
   wire rd_fire;
   wire [31:0] run_cfg_view;
   wire stat_clear;

   function [31:0] merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [31:0] mask;
      begin
         merge = ((old_val & ~mask) | (new_val & mask)) & `PCG_GATE_MASK;
      end
   endfunction

   // write address and data are taken independently, in any order
   assign s_axi_awready_o = ~aw_full_reg;
   assign s_axi_wready_o = ~w_full_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = ~rvalid_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign irq_o = irq_reg;

   // a held response blocks execution, so one write is in flight
   assign wr_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign rd_fire = s_axi_arvalid_i & ~rvalid_reg;
   assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                   {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign run_cfg_view = {31'h00000000, auto_clock_gating_select_reg};

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         aw_full_reg <= 1'b0;
         awaddr_reg <= {ADDR_W{1'b0}};
      end else if (s_axi_awvalid_i && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         awaddr_reg <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_full_reg <= 1'b0;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         w_full_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else if (s_axi_wvalid_i && !w_full_reg) begin
         w_full_reg <= 1'b1;
         wdata_reg <= s_axi_wdata_i;
         wstrb_reg <= s_axi_wstrb_i;
      end else if (wr_fire) begin
         w_full_reg <= 1'b0;
      end
   end

   always @* begin
      case (awaddr_reg[11:0])
         `PCG_RUN_GATE_OFS: wr_hit = 1'b1;
         `PCG_SLEEP_GATE_OFS: wr_hit = 1'b1;
         `PCG_DEEP_GATE_OFS: wr_hit = 1'b1;
         `PCG_RUN_CFG_OFS: wr_hit = 1'b1;
         `PCG_IRQ_STAT_OFS: wr_hit = 1'b1;
         `PCG_IRQ_MASK_OFS: wr_hit = 1'b1;
         `PCG_EFF_GATE_OFS: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // unmapped addresses answer with a slave error
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `PCG_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         run_clock_gate_1_reg <= `PCG_GATE_RESET;
         sleep_clock_gate_1_reg <= `PCG_GATE_RESET;
         deep_sleep_clock_gate_1_reg <= `PCG_GATE_RESET;
         auto_clock_gating_select_reg <= 1'b0;
         irq_mask_reg <= `PCG_IRQ_RESET;
      end else if (wr_fire) begin
         case (awaddr_reg[11:0])
            `PCG_RUN_GATE_OFS: begin
               run_clock_gate_1_reg <= merge(run_clock_gate_1_reg,
                                             wdata_reg, wmask);
            end
            `PCG_SLEEP_GATE_OFS: begin
               sleep_clock_gate_1_reg <= merge(sleep_clock_gate_1_reg,
                                               wdata_reg, wmask);
            end
            `PCG_DEEP_GATE_OFS: begin
               deep_sleep_clock_gate_1_reg <=
                  merge(deep_sleep_clock_gate_1_reg, wdata_reg, wmask);
            end
            `PCG_RUN_CFG_OFS: begin
               if (wstrb_reg[0]) begin
                  auto_clock_gating_select_reg <= wdata_reg[`PCG_ACG_BIT];
               end
            end
            `PCG_IRQ_MASK_OFS: begin
               irq_mask_reg <= merge(irq_mask_reg, wdata_reg, wmask);
            end
            // status clears in its own process so a new fault can win
            `PCG_IRQ_STAT_OFS: begin
               irq_mask_reg <= irq_mask_reg;
            end
            // read-only readback: the write is accepted and dropped
            `PCG_EFF_GATE_OFS: begin
               irq_mask_reg <= irq_mask_reg;
            end
            default: begin
               auto_clock_gating_select_reg <=
                  auto_clock_gating_select_reg;
            end
         endcase
      end
   end

   // write-one-to-clear of the status, applied in the status process
   assign stat_clear = wr_fire && (awaddr_reg[11:0] == `PCG_IRQ_STAT_OFS);

   // fault events win over a write-one-to-clear in the same cycle
   always @* begin
      irq_stat_next = irq_stat_reg | fault_layout;
      if (stat_clear) begin
         irq_stat_next = (irq_stat_reg & ~(wdata_reg & wmask)) |
                         fault_layout;
      end
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_stat_reg <= `PCG_IRQ_RESET;
      end else begin
         irq_stat_reg <= irq_stat_next & `PCG_GATE_MASK;
      end
   end

   // level output tracks the status it will hold after this edge
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // read path
   always @* begin
      rd_hit = 1'b1;
      case (s_axi_araddr_i[11:0])
         `PCG_RUN_GATE_OFS: rd_val = run_clock_gate_1_reg;
         `PCG_SLEEP_GATE_OFS: rd_val = sleep_clock_gate_1_reg;
         `PCG_DEEP_GATE_OFS: rd_val = deep_sleep_clock_gate_1_reg;
         `PCG_RUN_CFG_OFS: rd_val = run_cfg_view;
         `PCG_IRQ_STAT_OFS: rd_val = irq_stat_reg;
         `PCG_IRQ_MASK_OFS: rd_val = irq_mask_reg;
         `PCG_EFF_GATE_OFS: rd_val = en_layout;
         default: begin
            rd_val = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `PCG_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_val;
         rresp_reg <= rd_hit ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end

   // power state picks the gating register every cycle;
   // without auto gating the run values stay in force
   always @* begin
      if (!auto_clock_gating_select_reg) begin
         eff_layout = run_clock_gate_1_reg;
      end else if (deep_sleep_i) begin
         eff_layout = deep_sleep_clock_gate_1_reg;
      end else if (sleep_i) begin
         eff_layout = sleep_clock_gate_1_reg;
      end else begin
         eff_layout = run_clock_gate_1_reg;
      end
   end

   // scatter unit vectors back into the register layout
   always @* begin
      fault_layout = 32'h00000000;
      en_layout = 32'h00000000;
      for (i = 0; i < N_UNITS; i = i + 1) begin
         fault_layout[UNIT_POS[i*5 +: 5]] = fault_units[i];
         en_layout[UNIT_POS[i*5 +: 5]] = unit_en[i];
      end
   end

   genvar k;
   generate
      for (k = 0; k < N_UNITS; k = k + 1) begin : g_unit
         assign eff_units[k] = eff_layout[UNIT_POS[k*5 +: 5]];
         pcg_clk_gate u_gate (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .enable_i(eff_units[k]),
            .unit_clk_o(unit_clk_o[k]),
            .unit_en_o(unit_en[k])
         );
      end
   endgenerate

   assign unit_en_o = unit_en;

   pcg_fault_chk #(
      .N_UNITS(N_UNITS)
   ) u_fault (
      .access_valid_i(periph_valid_i),
      .access_sel_i(periph_sel_i),
      .unit_en_i(unit_en),
      .access_err_o(periph_err_o),
      .fault_units_o(fault_units)
   );

endmodule // pcg_top

// ---- bench/pcg_top_asserts.sv ----
`timescale 1ns/10ps
module pcg_top_asserts #(
   parameter N_UNITS = 10,
   parameter ADDR_W = 12
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic periph_valid_i,
   input wire logic [N_UNITS-1:0] periph_sel_i,
   input wire logic periph_err_o,
   input wire logic [N_UNITS-1:0] unit_clk_o,
   input wire logic [N_UNITS-1:0] unit_en_o
);
   chk_fault_on_gated: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      periph_err_o == (periph_valid_i && |(periph_sel_i & ~unit_en_o)))
      else $error("fault flag disagrees with gated select");
   // high phase of the unit clock must equal the enable
   chk_clk_follows_en: assert property (
      @(negedge core_clk_i) disable iff (!rst_n_i) unit_clk_o == unit_en_o)
      else $error("unit clock high phase differs from enable");
   chk_clk_low_phase: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i) unit_clk_o == '0)
      else $error("unit clock high during low phase");
   chk_reset_all_off: assert property (
      @(posedge core_clk_i) !rst_n_i |=>
      unit_en_o == '0 && !s_axi_bvalid_o && !s_axi_rvalid_o)
      else $error("units or responses active after reset");
   chk_read_answer: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_axi_arvalid_i && !s_axi_rvalid_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   chk_arready_free: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_axi_arready_o == !s_axi_rvalid_o)
      else $error("read address ready wrong");
   chk_rdata_holds: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
      $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
      else $error("read answer dropped before ready");
   chk_bresp_holds: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
      $stable(s_axi_bresp_o))
      else $error("write answer dropped before ready");
   chk_reserved_zero: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      s_axi_rvalid_o |-> (s_axi_rdata_o & 32'hfff0afe8) == 32'h0)
      else $error("reserved bits read nonzero");
endmodule // pcg_top_asserts

bind pcg_top pcg_top_asserts #(.N_UNITS(N_UNITS), .ADDR_W(ADDR_W)) u_chk (.*);

// ---- bench/pcg_periph_model.sv ----
`timescale 1ns/10ps
module pcg_periph_model #(
   parameter N = 10
) (
   input wire logic core_clk_i,
   input wire logic [N-1:0] unit_clk_i,
   input wire logic periph_err_i,
   output logic periph_valid_o,
   output logic [N-1:0] periph_sel_o
);
   integer pulses [0:N-1];
   genvar g;
   initial begin
      periph_valid_o = 1'h0;
      periph_sel_o = '0;
   end
   generate
      for (g = 0; g < N; g = g + 1) begin : g_cnt
         initial pulses[g] = 0;
         always @(posedge unit_clk_i[g]) pulses[g] = pulses[g] + 1;
      end
   endgenerate
   task access(input integer k, output logic err);
      @(posedge core_clk_i);
      periph_valid_o <= 1'h1;
      periph_sel_o <= {{(N-1){1'h0}}, 1'h1} << k;
      @(posedge core_clk_i);
      err = periph_err_i;
      periph_valid_o <= 1'h0;
      // released select toggles so stale values never match
      periph_sel_o <= ~periph_sel_o;
   endtask
endmodule // pcg_periph_model

// ---- bench/test_pcg_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) \
   n_tests = n_tests + 1; \
   if ((g) !== (e)) begin \
      fail_count = fail_count + 1; \
      $display("ERROR %s expected %h seen %h", nm, e, g); \
   end
module test_pcg_top;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [11:0] awaddr = '0;
   logic [11:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0;
   logic wvalid = 1'h0;
   logic bready = 1'h0;
   logic arvalid = 1'h0;
   logic rready = 1'h0;
   logic sleep = 1'h0;
   logic deep = 1'h0;
   wire awready, wready, bvalid, arready, rvalid, pvalid, perr, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [9:0] psel, uclk, uen;
   integer fail_count = 0;
   integer n_tests = 0;
   logic [1:0] resp;
   logic [31:0] rd_val;
   logic err;
   localparam int POS [10] = '{0, 1, 2, 4, 12, 14, 16, 17, 18, 19};
   always #12.5 clk = ~clk;
   pcg_top dut (.core_clk_i(clk), .rst_n_i(rst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .sleep_i(sleep), .deep_sleep_i(deep),
      .periph_valid_i(pvalid), .periph_sel_i(psel), .periph_err_o(perr),
      .unit_clk_o(uclk), .unit_en_o(uen), .irq_o(irq));
   pcg_periph_model u_per (.core_clk_i(clk), .unit_clk_i(uclk),
      .periph_err_i(perr), .periph_valid_o(pvalid), .periph_sel_o(psel));
   task end_sim;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task timeout;
      fail_count = fail_count + 1;
      $display("ERROR bus answer expected 1 seen 0");
      end_sim;
   endtask
   task wr(input [11:0] a, input [31:0] d);
      integer i;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'h0;
            @(posedge clk);
            return;
         end
      end
      timeout;
   endtask
   task rd(input [11:0] a);
      integer i;
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 40; i = i + 1) begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'h0;
         if (rvalid) begin
            rd_val = rdata;
            resp = rresp;
            rready <= 1'h0;
            @(posedge clk);
            return;
         end
      end
      timeout;
   endtask
   task t_reset;
      integer i;
      for (i = 0; i < 3; i = i + 1) begin
         rd(12'h104 + 12'(i * 16));
         `CHK("gate reset", 32'h0, rd_val)
         `CHK("gate read resp", 2'h0, resp)
      end
      `CHK("enables after reset", 10'h0, uen)
   endtask
   task t_fields;
      integer k;
      integer p0;
      for (k = 0; k < 10; k = k + 1) begin
         wr(12'h104, 32'h1 << POS[k]);
         repeat (2) @(posedge clk);
         `CHK("unit enable", 10'h1 << k, uen)
         @(negedge clk);
         p0 = u_per.pulses[k];
         repeat (4) @(negedge clk);
         `CHK("unit pulses", 4, u_per.pulses[k] - p0)
         u_per.access(k, err);
         `CHK("open access", 1'h0, err)
         u_per.access((k + 1) % 10, err);
         `CHK("gated access", 1'h1, err)
      end
   endtask
   task t_reserved;
      wr(12'h114, 32'hffffffff);
      rd(12'h114);
      `CHK("sleep gate writable", 32'h000f5017, rd_val)
      wstrb <= 4'h1;
      wr(12'h104, 32'hffffffff);
      `CHK("strobed write resp", 2'h0, resp)
      wstrb <= 4'hf;
      rd(12'h104);
      `CHK("byte lane write", 32'h00080017, rd_val)
      wr(12'h300, 32'h1);
      `CHK("unmapped write", 2'h2, resp)
      rd(12'h300);
      `CHK("unmapped read", 2'h2, resp)
   endtask
   task t_sleep;
      wr(12'h104, 32'h1);
      wr(12'h114, 32'h2);
      wr(12'h124, 32'h4);
      sleep <= 1'h1;
      repeat (2) @(posedge clk);
      `CHK("sleep no auto", 10'h001, uen)
      wr(12'h060, 32'h1);
      repeat (2) @(posedge clk);
      `CHK("sleep auto", 10'h002, uen)
      rd(12'h208);
      `CHK("effective enables", 32'h00000002, rd_val)
      rd(12'h060);
      `CHK("auto gating readback", 32'h00000001, rd_val)
      deep <= 1'h1;
      repeat (2) @(posedge clk);
      `CHK("deep sleep", 10'h004, uen)
      sleep <= 1'h0;
      deep <= 1'h0;
      repeat (2) @(posedge clk);
      `CHK("run again", 10'h001, uen)
      wr(12'h060, 32'h0);
   endtask
   task t_irq;
      wr(12'h200, 32'h000f5017);
      wr(12'h204, 32'h10);
      rd(12'h204);
      `CHK("irq mask readback", 32'h00000010, rd_val)
      wr(12'h104, 32'h0);
      u_per.access(0, err);
      repeat (2) @(posedge clk);
      `CHK("masked event irq", 1'h0, irq)
      u_per.access(3, err);
      repeat (2) @(posedge clk);
      `CHK("unmasked event irq", 1'h1, irq)
      rd(12'h200);
      `CHK("fault status", 32'h11, rd_val)
      wr(12'h200, 32'h10);
      repeat (2) @(posedge clk);
      `CHK("irq after clear", 1'h0, irq)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset;
      t_fields;
      t_reserved;
      t_sleep;
      t_irq;
      // second reset with the sync serial unit running
      wr(12'h104, 32'h10);
      repeat (2) @(posedge clk);
      `CHK("running before reset", 10'h008, uen)
      rst_n <= 1'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset;
      end_sim;
   end
endmodule // test_pcg_top
